// File: bench/field_side_model.sv
// Far side: switches, safety relays and the power stage's baseblock report.
// Assumes the bench sets wanted levels; they appear one pclk edge later.
`timescale 1ns/1ns
module field_side_model (
  input  wire       pclk,
  input  wire [6:0] want_pins,
  input  wire [1:0] want_safe,
  input  wire       hold_bb,
  input  wire       motor_power_en,
  output reg  [6:0] seq_pins = 7'h00,
  output reg        safe_off_input_a = 1'b0,
  output reg        safe_off_input_b = 1'b0,
  output reg        baseblock_fb = 1'b1
);
  // Contacts follow the wanted levels; each relay follows its own wanted bit, so one can be on alone
  always @(posedge pclk) begin
    seq_pins <= want_pins;
    safe_off_input_a <= want_safe[0];
    safe_off_input_b <= want_safe[1];
  end
  // Stage reports baseblock once current is gone, or when held there
  always @(posedge pclk) begin
    baseblock_fb <= hold_bb | ~motor_power_en;
  end
endmodule // field_side_model

// File: bench/input_alloc_asserts.sv
// Port checks of the input routing and safe-off block.
// Assumes one pclk domain; bound to the design at the foot.
`timescale 1ns/1ns
module input_alloc_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        safe_off_input_a,
  input wire        safe_off_input_b,
  input wire        baseblock_fb,
  input wire        motor_power_en,
  input wire        safe_state_monitor_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Seven edges cover synchroniser and filter, so glitches never trip a check
  sequence both_on_s;
    safe_off_input_a && safe_off_input_b;
  endsequence
  sequence setup_s;
    psel && !penable;
  endsequence
  a_power_cut:
    assert property (!(safe_off_input_a && safe_off_input_b) [*7] |-> !motor_power_en) else $error("power not cut");
  a_power_on:
    assert property (both_on_s [*7] |-> motor_power_en) else $error("power not enabled");
  a_monitor_on:
    assert property ((safe_off_input_a && safe_off_input_b && baseblock_fb) [*7] |-> safe_state_monitor_out)
      else $error("monitor not on");
  a_monitor_fb_off:
    assert property (!baseblock_fb [*7] |-> !safe_state_monitor_out) else $error("monitor on without baseblock");
  a_monitor_input_off:
    assert property (!safe_off_input_a [*7] |-> !safe_state_monitor_out) else $error("monitor on with input off");
  a_ready_next:
    assert property (setup_s |=> pready) else $error("no ready after setup");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_slverr_map:
    assert property (pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0)) else $error("wrong slave error");
endmodule // input_alloc_asserts

bind servo_input_alloc_and_safe_off input_alloc_asserts input_alloc_asserts_i (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .safe_off_input_a, .safe_off_input_b, .baseblock_fb, .motor_power_en,
  .safe_state_monitor_out);

// File: bench/tb_top.sv
// Bench: register sweeps of every digit code, safe-off combinations, a glitch.
// Assumes the design header on the include path and the far-side model.
`timescale 1ns/1ns
`include "input_alloc_defines.vh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold_bb;
  logic        safe_off_input_a, safe_off_input_b, baseblock_fb, motor_power_en, safe_state_monitor_out;
  logic        fwd_stop, rev_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  seq_pins, want_pins, p;
  logic [1:0]  want_safe;
  logic [7:0]  f;
  int          n_errors, checks_done;
  servo_input_alloc_and_safe_off servo_input_alloc_and_safe_off_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .seq_pins, .safe_off_input_a, .safe_off_input_b, .baseblock_fb,
    .motor_power_en, .safe_state_monitor_out, .fwd_travel_limit(f[0]), .rev_travel_limit(f[1]),
    .fwd_torque_clamp(f[2]), .rev_torque_clamp(f[3]), .home_slowdown_switch(f[4]), .capture_trigger_1(f[5]),
    .capture_trigger_2(f[6]), .capture_trigger_3(f[7]), .fwd_stop, .rev_stop);
  field_side_model field_side_model_i (.pclk, .want_pins, .want_safe, .hold_bb, .motor_power_en, .seq_pins,
    .safe_off_input_a, .safe_off_input_b, .baseblock_fb);
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready as long as it takes, the watchdog ends a dead wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic route(input logic [3:0] c, input logic [6:0] q, input logic latch);
    if (c == 4'h7) return 1'b1;
    if (c == 4'h8) return 1'b0;
    if (latch && !(c inside {4'h4, 4'h5, 4'h6, 4'hD, 4'hE, 4'hF})) return 1'b0;
    return (c < 4'h7) ? q[c] : ~q[c - 4'h9];
  endfunction
  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, want_pins, hold_bb} = '0;
    want_safe = 2'h3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_ROUTE_A, 32'h0);
    check(rd, 32'h00008821);
    apb(1'b0, `REG_ROUTE_B, 32'h0);
    check(rd, 32'h00008888);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    // Every code on all functions at once; one pin differs from the rest, none for codes 7 and 8
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, `REG_ROUTE_A, {16'h0, {4{c[3:0]}}});
      apb(1'b1, `REG_ROUTE_B, {16'h0, {4{c[3:0]}}});
      for (int lv = 0; lv < 2; lv++) begin
        p = (c < 7) ? 7'h01 << c : (c > 8) ? 7'h01 << (c - 9) : 7'h7F;
        @(posedge pclk);
        want_pins <= lv ? p : ~p;
        repeat (8) @(posedge pclk);
        p = lv ? p : ~p;
        check(f, {{3{route(c[3:0], p, 1'b1)}}, {5{route(c[3:0], p, 1'b0)}}});
        check({fwd_stop, rev_stop}, {2{route(c[3:0], p, 1'b0)}});
      end
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      want_safe <= k[1:0];
      hold_bb <= k[2];
      // Baseblock report follows power through its own chain; wait past both
      repeat (16) @(posedge pclk);
      check({motor_power_en, safe_state_monitor_out}, {k[0] & k[1], k[0] & k[1] & k[2]});
      apb(1'b0, `REG_STATUS, 32'h0);
      check(rd[9:8], {k[0] & k[1] & k[2], k[0] & k[1]});
    end
    apb(1'b1, `REG_ROUTE_A, 32'h0); // Codes 0 keep the travel limits at factory polarity
    @(posedge pclk);
    want_pins <= 7'h01;
    @(posedge pclk);
    want_pins <= 7'h00;
    // Look every cycle, so a pulse let through would be seen while it stands
    repeat (8) begin
      @(posedge pclk);
      check(f[0], 1'b0);
    end
    apb(1'b0, `REG_PINS, 32'h0);
    check(rd[9:0], 10'h380);
    report_and_stop;
  end
endmodule // tb_top

// File: pkg/input_alloc_defines.vh
// Shared constants for the sequence input allocation and safe-off logic.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef INPUT_ALLOC_DEFINES_VH
`define INPUT_ALLOC_DEFINES_VH

// APB register byte offsets
`define REG_ROUTE_A        12'h000
`define REG_ROUTE_B        12'h004
`define REG_STATUS         12'h008
`define REG_PINS           12'h00C

// Field positions of the route registers (4-bit digits)
`define FLD_FWD_LIMIT      0
`define FLD_REV_LIMIT      4
`define FLD_FWD_CLAMP      8
`define FLD_REV_CLAMP      12
`define FLD_SLOWDOWN       0
`define FLD_CAPTURE1       4
`define FLD_CAPTURE2       8
`define FLD_CAPTURE3       12

// Reset values of the route registers
`define ROUTE_A_RESET      16'h8821
`define ROUTE_B_RESET      16'h8888

// Digit codes
`define CODE_FORCE_ON      4'h7
`define CODE_FORCE_OFF     4'h8
`define CODE_INV_BASE      4'h9

// Synchroniser depth
`define SYNC_STAGES        3

`endif

// File: rtl/route_digit_decode.v
// One routing digit: picks a synchronised pin, applies polarity or forcing.
// Assumes pin levels are already synchronised to pclk; purely combinational.
`timescale 1ns/1ns
`include "input_alloc_defines.vh"

module route_digit_decode #(
  parameter LATCH_ONLY = 0
) (
  input  wire [3:0] digit,
  input  wire [6:0] pins,
  output reg        active
);

  reg [2:0] sel;
  reg [3:0] inv_index;

  // Index 0..6 is pin 13,7,8,9,10,11,12; high codes invert
  always @* begin
    sel       = 3'h0;
    inv_index = 4'h0;
    active    = 1'b0;
    if (digit == `CODE_FORCE_ON) begin
      active = 1'b1;
    end else if (digit == `CODE_FORCE_OFF) begin
      active = 1'b0;
    end else if (digit < `CODE_FORCE_ON) begin
      sel    = digit[2:0];
      active = pins[sel];
      if (LATCH_ONLY != 0 && digit < 4'h4)
        active = 1'b0; // Invalid latch routes read inactive
    end else begin
      // Codes 9..F fold onto indices 0..6; the difference fits four bits
      inv_index = digit - `CODE_INV_BASE;
      sel       = inv_index[2:0];
      active = ~pins[sel];
      if (LATCH_ONLY != 0 && digit < 4'hD)
        active = 1'b0;
    end
  end

endmodule // route_digit_decode

// File: rtl/servo_input_alloc_and_safe_off.v
// Sequence input routing and hardwire safe-off monitor with an APB slave.
// Assumes pins are asynchronous; baseblock feedback comes from the power stage.
`timescale 1ns/1ns
`include "input_alloc_defines.vh"

// Functional notes
// - Motor current is cut whenever either safe-off input is off, and enabled only while both are on.
// - The monitor output is on only when both safe-off inputs are asserted and the power stage reports baseblock.
// - Software digits choose which pin feeds each limit, slowdown and capture function.
// - Digits 0-6 pick pins 13,7..12 directly, 9-F the same inverted, 7 forces active and 8 forces inactive.
// - Capture functions accept only pins 10-12 via codes 4-6 or D-F, plus 7 and 8.
// - A pin shared by several functions drives all of them at once.
// - An active travel limit stops the servomotor.
module servo_input_alloc_and_safe_off (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [6:0]  seq_pins,
  input  wire        safe_off_input_a,
  input  wire        safe_off_input_b,
  input  wire        baseblock_fb,
  output reg         motor_power_en,
  output reg         safe_state_monitor_out,
  output reg         fwd_travel_limit,
  output reg         rev_travel_limit,
  output reg         fwd_torque_clamp,
  output reg         rev_torque_clamp,
  output reg         home_slowdown_switch,
  output reg         capture_trigger_1,
  output reg         capture_trigger_2,
  output reg         capture_trigger_3,
  output reg         fwd_stop,
  output reg         rev_stop
);

  // Pin chains: three stages, then the agreed level
  reg  [6:0]  pin_s1;
  reg  [6:0]  pin_s2;
  reg  [6:0]  pin_s3;
  reg  [6:0]  pin_level;
  reg  [6:0]  next_pin_level;
  // Safe-off chains: bit 0 input a, bit 1 input b, bit 2 baseblock report
  reg  [2:0]  safe_s1;
  reg  [2:0]  safe_s2;
  reg  [2:0]  safe_s3;
  reg  [2:0]  safe_level;
  reg  [2:0]  next_safe_level;
  // Routing digits as software wrote them
  reg  [15:0] route_a;
  reg  [15:0] route_b;
  // Routed function levels and safety terms, before the output flops
  wire [7:0]  func_act;
  wire        both_on;
  wire        in_baseblock;
  wire        next_motor_power_en;
  wire        next_monitor;
  // Bus decode and read path
  reg  [3:0]  reg_hit;
  wire        setup_phase;
  wire        wr_en;
  wire        rd_en;
  reg  [31:0] next_prdata;
  reg         next_err;
  integer     i;

  // Agreement of stages two and three; a disagreement keeps the old level,
  // so a pulse shorter than two edges never reaches the routing
  function agree;
    input s2;
    input s3;
    input held;
    agree = (s2 & s3) | (held & (s2 | s3));
  endfunction

  // Next agreed levels, bit by bit, for pins and safe-off inputs alike
  always @* begin
    next_pin_level  = 7'h00;
    next_safe_level = 3'h0;
    for (i = 0; i < 7; i = i + 1) begin
      next_pin_level[i] = agree(pin_s2[i], pin_s3[i], pin_level[i]);
    end
    for (i = 0; i < 3; i = i + 1) begin
      next_safe_level[i] = agree(safe_s2[i], safe_s3[i], safe_level[i]);
    end
  end

  // Pin chains; stage one may be metastable, so only stage two reads it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1    <= 7'h00;
      pin_s2    <= 7'h00;
      pin_s3    <= 7'h00;
      pin_level <= 7'h00;
    end else begin
      pin_s1    <= seq_pins;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= next_pin_level;
    end
  end

  // Safe-off chains; reset reads both inputs off, so power starts cut
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_s1    <= 3'h0;
      safe_s2    <= 3'h0;
      safe_s3    <= 3'h0;
      safe_level <= 3'h0;
    end else begin
      safe_s1    <= {baseblock_fb, safe_off_input_b, safe_off_input_a};
      safe_s2    <= safe_s1;
      safe_s3    <= safe_s2;
      safe_level <= next_safe_level;
    end
  end

  // One decoder per function; all read the same pin vector, so a shared pin
  // drives every function routed to it in the same cycle

  // Forward travel limit
  route_digit_decode #(
    .LATCH_ONLY (0)
  ) u_fwd_lim (
    .digit      (route_a[`FLD_FWD_LIMIT +: 4]),
    .pins       (pin_level),
    .active     (func_act[0])
  );

  // Reverse travel limit
  route_digit_decode #(
    .LATCH_ONLY (0)
  ) u_rev_lim (
    .digit      (route_a[`FLD_REV_LIMIT +: 4]),
    .pins       (pin_level),
    .active     (func_act[1])
  );

  // Forward torque clamp
  route_digit_decode #(
    .LATCH_ONLY (0)
  ) u_fwd_clp (
    .digit      (route_a[`FLD_FWD_CLAMP +: 4]),
    .pins       (pin_level),
    .active     (func_act[2])
  );

  // Reverse torque clamp
  route_digit_decode #(
    .LATCH_ONLY (0)
  ) u_rev_clp (
    .digit      (route_a[`FLD_REV_CLAMP +: 4]),
    .pins       (pin_level),
    .active     (func_act[3])
  );

  // Homing slowdown switch
  route_digit_decode #(
    .LATCH_ONLY (0)
  ) u_slow (
    .digit      (route_b[`FLD_SLOWDOWN +: 4]),
    .pins       (pin_level),
    .active     (func_act[4])
  );

  // Capture 1 accepts pins 10 to 12 only
  route_digit_decode #(
    .LATCH_ONLY (1)
  ) u_cap1 (
    .digit      (route_b[`FLD_CAPTURE1 +: 4]),
    .pins       (pin_level),
    .active     (func_act[5])
  );

  // Capture 2, same pin limits
  route_digit_decode #(
    .LATCH_ONLY (1)
  ) u_cap2 (
    .digit      (route_b[`FLD_CAPTURE2 +: 4]),
    .pins       (pin_level),
    .active     (func_act[6])
  );

  // Capture 3, same pin limits
  route_digit_decode #(
    .LATCH_ONLY (1)
  ) u_cap3 (
    .digit      (route_b[`FLD_CAPTURE3 +: 4]),
    .pins       (pin_level),
    .active     (func_act[7])
  );

  // Current may flow only while both redundant inputs read on
  assign both_on             = safe_level[0] & safe_level[1];
  assign next_motor_power_en = both_on;
  // The monitor also needs the stage to report baseblock; a stale report
  // can lift it for a few edges after the inputs come on
  assign in_baseblock        = safe_level[2];
  assign next_monitor        = both_on & in_baseblock;

  // Routed function outputs, one flop each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_travel_limit     <= 1'b0;
      rev_travel_limit     <= 1'b0;
      fwd_torque_clamp     <= 1'b0;
      rev_torque_clamp     <= 1'b0;
      home_slowdown_switch <= 1'b0;
      capture_trigger_1    <= 1'b0;
      capture_trigger_2    <= 1'b0;
      capture_trigger_3    <= 1'b0;
    end else begin
      fwd_travel_limit     <= func_act[0];
      rev_travel_limit     <= func_act[1];
      fwd_torque_clamp     <= func_act[2];
      rev_torque_clamp     <= func_act[3];
      home_slowdown_switch <= func_act[4];
      capture_trigger_1    <= func_act[5];
      capture_trigger_2    <= func_act[6];
      capture_trigger_3    <= func_act[7];
    end
  end

  // Limit active means travel beyond range: halt that direction; held stopped in reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_stop <= 1'b1;
      rev_stop <= 1'b1;
    end else begin
      fwd_stop <= func_act[0];
      rev_stop <= func_act[1];
    end
  end

  // Power enable and monitor; both are off out of reset, the safe side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_power_en         <= 1'b0;
      safe_state_monitor_out <= 1'b0;
    end else begin
      motor_power_en         <= next_motor_power_en;
      safe_state_monitor_out <= next_monitor;
    end
  end

  // Transfer phases as the master presents them
  assign setup_phase = psel & ~penable;
  assign wr_en       = psel & penable & pwrite;
  assign rd_en       = setup_phase & ~pwrite;

  // Address decode, one-hot; shared by the write port and the read mux
  always @* begin
    reg_hit = 4'h0;
    if (paddr == `REG_ROUTE_A) begin
      reg_hit = 4'h1;
    end else if (paddr == `REG_ROUTE_B) begin
      reg_hit = 4'h2;
    end else if (paddr == `REG_STATUS) begin
      reg_hit = 4'h4;
    end else if (paddr == `REG_PINS) begin
      reg_hit = 4'h8;
    end
  end

  // Route registers, written at the access edge; status and pins are read-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_a <= `ROUTE_A_RESET;
      route_b <= `ROUTE_B_RESET;
    end else if (wr_en) begin
      if (reg_hit[0]) begin
        route_a <= pwdata[15:0];
      end else if (reg_hit[1]) begin
        route_b <= pwdata[15:0];
      end
    end
  end

  // Read mux prepared in setup so prdata is a flop during access
  always @* begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    if (reg_hit[0]) begin
      next_prdata = {16'h0000, route_a};
    end else if (reg_hit[1]) begin
      next_prdata = {16'h0000, route_b};
    end else if (reg_hit[2]) begin
      next_prdata = {20'h00000, fwd_stop, rev_stop, safe_state_monitor_out, motor_power_en,
                     capture_trigger_3, capture_trigger_2, capture_trigger_1, home_slowdown_switch,
                     rev_torque_clamp, fwd_torque_clamp, rev_travel_limit, fwd_travel_limit};
    end else if (reg_hit[3]) begin
      next_prdata = {22'h000000, safe_level, pin_level};
    end else begin
      next_err = 1'b1; // Unmapped address answers with an error
    end
  end

  // Zero-wait answer: pready and pslverr stand for the access cycle only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & next_err;
    end
  end

  // Read data held until the next read, so a slow master still sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

endmodule // servo_input_alloc_and_safe_off
